// File: sbgt_pkg.sv
`default_nettype none

package sbgt_pkg;

    // ------------------------------------------------------------
    // Register addresses on the special function register port
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h98;    // Serial control and flags
    localparam logic [7:0] ADDR_RELOAD = 8'h9A;  // Generator reload value
    localparam logic [7:0] ADDR_COUNT = 8'h9B;   // Generator counter
    localparam logic [7:0] ADDR_CFG = 8'h9C;     // Port configuration

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CFG = 8'h20;      // Bit order control starts at 1
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_RELOAD = 8'h00;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;  // Answer to an unknown address

    // ------------------------------------------------------------
    // Cycle counts of the fixed dividers
    // ------------------------------------------------------------
    localparam int DIV_SYS12 = 12;               // Slow shift rate and count clock
    localparam int DIV_SYS4 = 4;                 // Fast shift rate
    localparam int DIV_M2_LO = 64;               // Mode 2, rate select clear
    localparam int DIV_M2_HI = 192;              // Mode 2, rate select set
    localparam int SAMPLES_PER_BIT = 16;         // Oversampling of modes 1 and 3
    localparam logic [7:0] GEN_MAX = 8'hFF;      // Counter value before rollover

    // ------------------------------------------------------------
    // Serial operating modes {mode bit 2, mode bit 0, mode bit 1}
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SBGT_SHIFT = 3'b000,
        SBGT_UART8 = 3'b001,
        SBGT_UART9_FIX = 3'b010,
        SBGT_UART9_VAR = 3'b011,
        SBGT_SPI_MASTER = 3'b100,
        SBGT_RSVD5 = 3'b101,
        SBGT_RSVD6 = 3'b110,
        SBGT_RSVD7 = 3'b111
    } sbgt_mode_e;

    // ------------------------------------------------------------
    // Register layouts, bit 7 first
    // ------------------------------------------------------------
    typedef struct packed {
        logic mode_b2;           // Mode bit 2
        logic mode0_rate_select; // Mode 0/2/4 rate select
        logic bit_order_ctl;     // Bit order, or timer width in timer mode
        logic gen_run;           // Generator run
        logic double_rate_en;    // Double baud rate
        logic gen_clk_select;    // 0: clock/12, 1: clock
        logic clk_out_en;        // Clock output enable
        logic timer_mode_en;     // Timer mode
    } sbgt_cfg_s;

    typedef struct packed {
        logic mode_b0;           // Mode bit 0
        logic mode_b1;           // Mode bit 1
        logic addr_match_en;     // Address recognition enable
        logic rx_enable;         // Receive enable
        logic tx_ninth_bit;      // Ninth transmit bit
        logic rx_ninth_bit;      // Ninth received bit
        logic tx_flag;           // Transmit flag
        logic rx_flag;           // Receive flag
    } sbgt_ctrl_s;

endpackage

`default_nettype wire

// File: sbgt_sync.sv
`timescale 1ns/10ps
`default_nettype none

// Two flip-flop synchroniser for pin levels
module sbgt_sync
#(
    parameter int WIDTH = 1
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // First stage, read only by the second stage
    logic [WIDTH-1:0] meta;

    // --------------------------------------------------------
    // Synchroniser stages
    // --------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta <= '1;
            sync_out <= '1;
        end
        else
        begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule // sbgt_sync

`default_nettype wire

// File: sbgt_tick_div.sv
`timescale 1ns/10ps
`default_nettype none

// Free running divider giving one pulse every DIV clocks
module sbgt_tick_div
#(
    parameter int DIV = 12
)
(
    input wire logic clk,
    input wire logic rst,
    output logic tick
);

    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    // Cycle counter
    logic [CW-1:0] cnt;
    wire at_last = (cnt == LAST);

    // --------------------------------------------------------
    // Counter and registered pulse
    // --------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt <= '0;
            tick <= 1'b0;
        end
        else
        begin
            cnt <= at_last ? '0 : cnt + CW'(1);
            tick <= at_last;
        end
    end

endmodule // sbgt_tick_div

`default_nettype wire

// File: sbgt_core.sv
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Mode 0/4 shift clock: /12 or /4
// - Mode 2 uses /32,/64 or /96,/192
// - Bit order MSB/LSB first; resets to 1
// - Timer mode: order bit selects 16/8-bit
// - Counter runs only while run bit set
// - Double-rate bit doubles mode 1/2/3 baud rate
// - Count clock: system/12 or system clock
// - Clock pin driven only when enabled
// - Timer mode disables port, detects receive pin
// - 8-bit up-counter reloads on overflow
// - Overflow times modes 1/3, sixteen samples
// - Reload write loads counter when stopped
// - Clock output toggles each overflow
// - Overflow toggle always feeds peripherals
// - Mode 2 rate: clock*2^double over 64/192
// - Mode 1/3: 2^double/32 of overflow rate
// - Timer mode: overflow and detector set flags
// - Receive detector edge chosen by ninth bit
// - Power-down: level detector may wake processor
// - Timer 1 overflow cascades for 16 bits
// - Clock output enable masks detector interrupt
module sbgt_core
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic t1_overflow,
    input wire logic eng_tx_done,
    input wire logic eng_rx_done,
    input wire logic eng_rx_ninth,
    input wire logic power_down,
    input wire logic serial_irq_en,
    input wire logic rx_pin,
    output logic gen_overflow,
    output logic periph_clk,
    output logic gen_clk_out,
    output logic gen_clk_out_oe,
    output logic bit_tick,
    output logic sample_tick,
    output logic lsb_first,
    output logic serial_en,
    output logic [2:0] serial_mode,
    output logic serial_irq_req,
    output logic wake_req
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    sbgt_pkg::sbgt_cfg_s cfg;        // Port configuration
    sbgt_pkg::sbgt_ctrl_s ctrl;      // Serial control and flags
    logic [7:0] reload_reg;          // Reload value
    logic [7:0] gen_counter;         // Generator counter
    logic gen_toggle;                // Overflow divided by two
    logic ovf_half;                  // Overflow pair phase
    logic [3:0] samp_cnt;            // Samples within a bit
    logic [7:0] fix_cnt;             // Fixed rate divider
    logic rx_prev;                   // Previous receive pin level

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    wire wr_ctrl = sfr_wr && (sfr_addr == sbgt_pkg::ADDR_CTRL);
    wire wr_reload = sfr_wr && (sfr_addr == sbgt_pkg::ADDR_RELOAD);
    wire wr_count = sfr_wr && (sfr_addr == sbgt_pkg::ADDR_COUNT);
    wire wr_cfg = sfr_wr && (sfr_addr == sbgt_pkg::ADDR_CFG);
    wire sbgt_pkg::sbgt_ctrl_s wctrl = sbgt_pkg::sbgt_ctrl_s'(sfr_wdata);

    // Read data selection
    wire [7:0] rd_sel =
        (sfr_addr == sbgt_pkg::ADDR_CTRL) ? ctrl :
        (sfr_addr == sbgt_pkg::ADDR_RELOAD) ? reload_reg :
        (sfr_addr == sbgt_pkg::ADDR_COUNT) ? gen_counter :
        (sfr_addr == sbgt_pkg::ADDR_CFG) ? cfg :
        sbgt_pkg::RD_UNMAPPED;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    wire timer_on = cfg.timer_mode_en;
    wire timer16 = timer_on && !cfg.bit_order_ctl;
    wire sbgt_pkg::sbgt_mode_e mode =
        sbgt_pkg::sbgt_mode_e'({cfg.mode_b2, ctrl.mode_b0, ctrl.mode_b1});
    wire var_mode = (mode == sbgt_pkg::SBGT_UART8) ||
                    (mode == sbgt_pkg::SBGT_UART9_VAR);
    wire shift_mode = (mode == sbgt_pkg::SBGT_SHIFT) ||
                      (mode == sbgt_pkg::SBGT_SPI_MASTER);
    wire fix2_mode = (mode == sbgt_pkg::SBGT_UART9_FIX);

    // ------------------------------------------------------------
    // Count clock selection
    // ------------------------------------------------------------
    wire pre12_tick;

    // System clock divided by twelve
    sbgt_tick_div #(
        .DIV(sbgt_pkg::DIV_SYS12)
    ) u_pre12 (
        .clk(clk),
        .rst(rst),
        .tick(pre12_tick)
    );

    // Timer 1 overflow in the cascaded timer, else the selected clock
    wire count_src = timer16 ? t1_overflow :
                     (cfg.gen_clk_select ? 1'b1 : pre12_tick);
    wire count_en = cfg.gen_run && count_src;
    wire ovf = count_en && (gen_counter == sbgt_pkg::GEN_MAX);

    // ------------------------------------------------------------
    // Generator counter and reload
    // ------------------------------------------------------------
    wire [7:0] next_counter =
        wr_count ? sfr_wdata :
        (wr_reload && !cfg.gen_run) ? sfr_wdata :
        ovf ? reload_reg :
        count_en ? gen_counter + 8'h01 :
        gen_counter;

    // Counter, reload value and configuration
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cfg <= sbgt_pkg::sbgt_cfg_s'(sbgt_pkg::RST_CFG);
            reload_reg <= sbgt_pkg::RST_RELOAD;
            gen_counter <= sbgt_pkg::RST_COUNT;
        end
        else
        begin
            if (wr_cfg)
            begin
                cfg <= sbgt_pkg::sbgt_cfg_s'(sfr_wdata);
            end
            if (wr_reload)
            begin
                reload_reg <= sfr_wdata;
            end
            gen_counter <= next_counter;
        end
    end

    // ------------------------------------------------------------
    // Overflow toggle and clock output
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            gen_toggle <= 1'b0;
            gen_overflow <= 1'b0;
        end
        else
        begin
            gen_overflow <= ovf;
            if (ovf)
            begin
                gen_toggle <= !gen_toggle;
            end
        end
    end

    // Peripheral clock runs whatever the serial engine does
    assign periph_clk = gen_toggle;
    assign gen_clk_out = gen_toggle;
    assign gen_clk_out_oe = cfg.clk_out_en;

    // ------------------------------------------------------------
    // Variable rate timing for modes 1 and 3
    // ------------------------------------------------------------
    // Sixteen samples per bit; a sample every second overflow,
    // or every overflow when the rate is doubled
    wire next_sample = var_mode && !timer_on && ovf &&
                       (cfg.double_rate_en || ovf_half);
    wire samp_last = (samp_cnt == 4'(sbgt_pkg::SAMPLES_PER_BIT - 1));

    // Sample phase and sample counter
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ovf_half <= 1'b0;
            samp_cnt <= 4'h0;
        end
        else
        begin
            if (ovf)
            begin
                ovf_half <= !ovf_half;
            end
            if (next_sample)
            begin
                samp_cnt <= samp_last ? 4'h0 : samp_cnt + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Fixed rate timing for modes 0, 2 and 4
    // ------------------------------------------------------------
    // Mode 2 divisor halves when the rate is doubled
    wire [7:0] m2_div = cfg.mode0_rate_select ?
        8'(sbgt_pkg::DIV_M2_HI) : 8'(sbgt_pkg::DIV_M2_LO);
    wire [7:0] m2_limit = cfg.double_rate_en ? {1'b0, m2_div[7:1]} : m2_div;
    wire [7:0] shift_limit = cfg.mode0_rate_select ?
        8'(sbgt_pkg::DIV_SYS4) : 8'(sbgt_pkg::DIV_SYS12);
    wire [7:0] fix_limit = fix2_mode ? m2_limit : shift_limit;
    wire fix_run = serial_en && (shift_mode || fix2_mode);
    wire fix_hit = fix_run && (fix_cnt >= fix_limit - 8'h01);

    // Fixed divider restarts when the mode leaves fixed rates
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fix_cnt <= 8'h00;
        end
        else if (!fix_run || fix_hit)
        begin
            fix_cnt <= 8'h00;
        end
        else
        begin
            fix_cnt <= fix_cnt + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Engine strobes
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sample_tick <= 1'b0;
            bit_tick <= 1'b0;
        end
        else
        begin
            sample_tick <= next_sample;
            bit_tick <= (next_sample && samp_last) || fix_hit;
        end
    end

    assign serial_en = !timer_on;
    assign lsb_first = !timer_on && cfg.bit_order_ctl;
    assign serial_mode = mode;

    // ------------------------------------------------------------
    // Receive pin change detector
    // ------------------------------------------------------------
    wire rx_s;

    // Pin level into the clock domain
    sbgt_sync #(
        .WIDTH(1)
    ) u_rx_sync (
        .clk(clk),
        .rst(rst),
        .async_in(rx_pin),
        .sync_out(rx_s)
    );

    // Previous level for edge finding
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rx_prev <= 1'b1;
        end
        else
        begin
            rx_prev <= rx_s;
        end
    end

    wire rx_fall = rx_prev && !rx_s;
    wire rx_rise = !rx_prev && rx_s;
    wire rx_edge = ctrl.rx_ninth_bit ? rx_rise : rx_fall;
    wire rx_level = (rx_s == ctrl.rx_ninth_bit);
    wire det_arm = timer_on && ctrl.rx_enable;
    wire det_hit = det_arm && (power_down ? rx_level : rx_edge);

    // ------------------------------------------------------------
    // Serial control and flags
    // ------------------------------------------------------------
    wire tx_set = timer_on ? ovf : eng_tx_done;
    wire rx_set = timer_on ? det_hit : eng_rx_done;
    wire rb8_load = !timer_on && eng_rx_done;

    // Flags: a hardware set wins over a software clear
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl <= sbgt_pkg::sbgt_ctrl_s'(sbgt_pkg::RST_CTRL);
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl <= wctrl;
            end
            if (rb8_load)
            begin
                ctrl.rx_ninth_bit <= eng_rx_ninth;
            end
            ctrl.tx_flag <= (wr_ctrl ? wctrl.tx_flag : ctrl.tx_flag) || tx_set;
            ctrl.rx_flag <= (wr_ctrl ? wctrl.rx_flag : ctrl.rx_flag) || rx_set;
        end
    end

    // ------------------------------------------------------------
    // Interrupt request and wake-up
    // ------------------------------------------------------------
    // Timer mode gates each flag by its own enable
    wire tmr_tx_irq = ctrl.tx_flag && ctrl.tx_ninth_bit;
    wire tmr_rx_irq = ctrl.rx_flag && ctrl.rx_enable && !cfg.clk_out_en;
    assign serial_irq_req = timer_on ? (tmr_tx_irq || tmr_rx_irq) :
                            (ctrl.tx_flag || ctrl.rx_flag);

    // Level detector wakes the processor in power-down
    assign wake_req = power_down && serial_irq_en && det_arm &&
                      !cfg.clk_out_en && rx_level;

    // ------------------------------------------------------------
    // Read data register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sfr_rdata <= 8'h00;
        end
        else if (sfr_rd)
        begin
            sfr_rdata <= rd_sel;
        end
    end

endmodule // sbgt_core

`default_nettype wire

// File: sbgt_checker.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Checker on the generator and register pins
// ----------------------------------------
module sbgt_checker
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic gen_overflow,
    input wire logic periph_clk,
    input wire logic gen_clk_out,
    input wire logic gen_clk_out_oe,
    input wire logic lsb_first,
    input wire logic serial_en,
    input wire logic serial_irq_req
);
    logic [7:0] cfg_m; // Last configuration written
    logic tb8_m; // Last ninth transmit bit written
    logic [8:0] idle_n; // Cycles since the generator stopped
    wire cfg_wr = sfr_wr && sfr_addr == sbgt_pkg::ADDR_CFG;
    wire rld_wr = sfr_wr && sfr_addr == sbgt_pkg::ADDR_RELOAD;
    wire ctl_wr = sfr_wr && sfr_addr == sbgt_pkg::ADDR_CTRL;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Mirror of software writes
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cfg_m <= sbgt_pkg::RST_CFG;
            tb8_m <= 1'b0;
            idle_n <= 9'h000;
        end
        else
        begin
            cfg_m <= cfg_wr ? sfr_wdata : cfg_m;
            tb8_m <= ctl_wr ? sfr_wdata[3] : tb8_m;
            idle_n <= cfg_m[4] ? 9'h000 : idle_n + {8'h00, idle_n != 9'h1FF};
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    toggle_on_ovf_a: assert property ((gen_clk_out != $past(gen_clk_out)) == gen_overflow)
        else $error("clock output toggle not tied to overflow");
    periph_same_a: assert property (periph_clk == gen_clk_out)
        else $error("peripheral clock differs from clock output");
    pin_enable_a: assert property (gen_clk_out_oe == cfg_m[1])
        else $error("clock pin enable wrong");
    bit_order_a: assert property (lsb_first == (cfg_m[5] && !cfg_m[0]))
        else $error("bit order output wrong");
    port_release_a: assert property (serial_en == !cfg_m[0])
        else $error("serial enable wrong in timer mode");
    cfg_readback_a: assert property (sfr_rd && sfr_addr == sbgt_pkg::ADDR_CFG && !sfr_wr
        |=> sfr_rdata == cfg_m)
        else $error("configuration readback wrong");
    stop_hold_a: assert property (idle_n >= 9'd2 |-> !gen_overflow)
        else $error("overflow while generator stopped");
    reload_copy_a: assert property (rld_wr && !cfg_m[4] ##1 !sfr_wr ##1
        (sfr_rd && sfr_addr == sbgt_pkg::ADDR_COUNT && !sfr_wr) |=> sfr_rdata == $past(sfr_wdata, 3))
        else $error("stopped reload write did not load counter");
    timer_irq_a: assert property (gen_overflow && cfg_m[0] && tb8_m && !sfr_wr
        |-> ##[0:2] serial_irq_req)
        else $error("timer overflow raised no interrupt");

    cover property (gen_overflow && cfg_m[0]);
    cover property (gen_overflow && gen_clk_out_oe);
    cover property (serial_irq_req && cfg_m[0]);
endmodule // sbgt_checker

bind sbgt_core sbgt_checker chk (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .gen_overflow(gen_overflow),
    .periph_clk(periph_clk), .gen_clk_out(gen_clk_out), .gen_clk_out_oe(gen_clk_out_oe),
    .lsb_first(lsb_first), .serial_en(serial_en), .serial_irq_req(serial_irq_req));

`default_nettype wire

// File: sbgt_partner.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Shift engine and timer 1 stand-in
// ----------------------------------------
module sbgt_partner
#(
    parameter int T1_PER = 5
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic bit_tick,
    output logic t1_overflow,
    output logic eng_tx_done,
    output logic eng_rx_done,
    output logic eng_rx_ninth
);
    int t1_n; // Timer 1 phase
    int bits_n; // Bit times in the current frame

    // Timer 1 pulse train and a ten-bit frame end pulse
    initial
    begin
        t1_n = 0;
        bits_n = 0;
        t1_overflow = 1'b0;
        eng_tx_done = 1'b0;
        eng_rx_done = 1'b0;
        eng_rx_ninth = 1'b1;
        forever
        begin
            @(posedge clk);
            #2;
            t1_n = (t1_n + 1) % T1_PER;
            t1_overflow = !rst && t1_n == 0;
            bits_n = bit_tick ? (bits_n + 1) % 10 : bits_n;
            eng_tx_done = !rst && bit_tick && bits_n == 0;
            eng_rx_done = eng_tx_done;
        end
    end
endmodule // sbgt_partner

`default_nettype wire

// File: testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic t1_overflow, eng_tx_done, eng_rx_done, eng_rx_ninth;
    logic power_down = 1'b0;
    logic serial_irq_en = 1'b0;
    logic rx_pin = 1'b1;
    logic gen_overflow, periph_clk, gen_clk_out, gen_clk_out_oe, bit_tick, sample_tick;
    logic lsb_first, serial_en, serial_irq_req, wake_req;
    logic [2:0] serial_mode;
    int fail_count = 0;
    int n_compared = 0;
    // Rows: cfg, ctrl, reload, watched signal, expected period
    logic [39:0] rows [16] = '{
        40'h200000010C, 40'h6000000104, 40'hA00000010C, 40'hE000000104,
        40'h2080000140, 40'h2880000120, 40'h60800001C0, 40'h6880000160,
        40'h3400E00020, 40'h3000F80060,
        40'h3440FC0180, 40'h3C40FC0140, 40'h34C0FE0140, 40'h3440FC0308,
        40'h3600F00220, 40'h1100F00050};

    sbgt_core dut (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .t1_overflow(t1_overflow),
        .eng_tx_done(eng_tx_done), .eng_rx_done(eng_rx_done), .eng_rx_ninth(eng_rx_ninth),
        .power_down(power_down), .serial_irq_en(serial_irq_en), .rx_pin(rx_pin),
        .gen_overflow(gen_overflow), .periph_clk(periph_clk), .gen_clk_out(gen_clk_out),
        .gen_clk_out_oe(gen_clk_out_oe), .bit_tick(bit_tick), .sample_tick(sample_tick),
        .lsb_first(lsb_first), .serial_en(serial_en), .serial_mode(serial_mode),
        .serial_irq_req(serial_irq_req), .wake_req(wake_req));

    sbgt_partner #(.T1_PER(5)) peer (.clk(clk), .rst(rst), .bit_tick(bit_tick),
        .t1_overflow(t1_overflow), .eng_tx_done(eng_tx_done), .eng_rx_done(eng_rx_done),
        .eng_rx_ninth(eng_rx_ninth));

    // 40 MHz clock
    initial
    begin
        forever #12.5 clk = ~clk;
    end

    // ----------------------------------------
    // Access and compare tasks
    // ----------------------------------------
    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask

    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #2;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge clk);
        #2;
        sfr_wr = 1'b0;
    endtask

    task automatic sfr_read(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        #2;
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge clk);
        #2;
        sfr_rd = 1'b0;
        check("sfr_rdata", {8'h00, e}, {8'h00, sfr_rdata});
    endtask

    function automatic logic pick(input int s);
        return s == 0 ? gen_overflow : (s == 1 ? bit_tick : (s == 2 ? gen_clk_out : sample_tick));
    endfunction

    // Cycles between the second and third rise of a watched signal
    task automatic period(input int s, output int p, output int n);
        int c;
        int t0;
        logic pv;
        c = 0;
        t0 = 0;
        p = 0;
        n = 0;
        pv = 1'b1;
        while (n < 3 && c < 1500)
        begin
            @(posedge clk);
            #2;
            if (pick(s) && !pv)
            begin
                n++;
                t0 = (n == 2) ? c : t0;
                p = c - t0;
            end
            pv = pick(s);
            c++;
        end
    endtask

    // Pin level change, then flag readback
    task automatic pin(input logic lv, input logic [7:0] e);
        rx_pin = lv;
        repeat (6) @(posedge clk);
        sfr_read(sbgt_pkg::ADDR_CTRL, e);
    endtask

    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        #2000000;
        fail_count++;
        conclude();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        logic [39:0] r;
        int p;
        int n;
        repeat (12) @(posedge clk);
        #2;
        rst = 1'b0;
        sfr_read(sbgt_pkg::ADDR_CFG, 8'h20);
        sfr_read(sbgt_pkg::ADDR_CTRL, 8'h00);
        sfr_read(sbgt_pkg::ADDR_COUNT, 8'h00);
        sfr_read(8'h55, sbgt_pkg::RD_UNMAPPED);
        sfr_write(sbgt_pkg::ADDR_RELOAD, 8'hF0);
        sfr_read(sbgt_pkg::ADDR_COUNT, 8'hF0);
        sfr_write(sbgt_pkg::ADDR_COUNT, 8'h10);
        sfr_read(sbgt_pkg::ADDR_RELOAD, 8'hF0);
        sfr_read(sbgt_pkg::ADDR_COUNT, 8'h10);
        $display("test registers done");
        for (int i = 0; i < 16; i++)
        begin
            r = rows[i];
            sfr_write(sbgt_pkg::ADDR_CFG, 8'h20);
            sfr_write(sbgt_pkg::ADDR_CTRL, r[31:24]);
            sfr_write(sbgt_pkg::ADDR_RELOAD, r[23:16]);
            sfr_write(sbgt_pkg::ADDR_CFG, r[39:32]);
            period(int'(r[15:8]), p, n);
            check("period", {8'h00, r[7:0]}, p[15:0]);
            check("serial_mode", {13'h0000, r[39], r[31:30]}, {13'h0000, serial_mode});
        end
        $display("test rates done");
        sfr_write(sbgt_pkg::ADDR_CFG, 8'h24);
        period(0, p, n);
        check("overflows", 16'h0000, n[15:0]);
        $display("test stop done");
        sfr_write(sbgt_pkg::ADDR_RELOAD, 8'hF0);
        sfr_write(sbgt_pkg::ADDR_CFG, 8'h35);
        sfr_write(sbgt_pkg::ADDR_CTRL, 8'h08);
        period(0, p, n);
        check("serial_en", 16'h0000, {15'h0000, serial_en});
        check("irq", 16'h0001, {15'h0000, serial_irq_req});
        sfr_write(sbgt_pkg::ADDR_CFG, 8'h21);
        sfr_read(sbgt_pkg::ADDR_CTRL, 8'h0A);
        sfr_write(sbgt_pkg::ADDR_CTRL, 8'h10);
        pin(1'b0, 8'h11);
        check("irq", 16'h0001, {15'h0000, serial_irq_req});
        sfr_write(sbgt_pkg::ADDR_CTRL, 8'h14);
        pin(1'b1, 8'h15);
        sfr_write(sbgt_pkg::ADDR_CTRL, 8'h14);
        pin(1'b0, 8'h14);
        sfr_write(sbgt_pkg::ADDR_CTRL, 8'h10);
        pin(1'b0, 8'h10);
        power_down = 1'b1;
        serial_irq_en = 1'b1;
        pin(1'b0, 8'h11);
        check("wake_req", 16'h0001, {15'h0000, wake_req});
        power_down = 1'b0;
        sfr_write(sbgt_pkg::ADDR_CFG, 8'h23);
        check("irq", 16'h0000, {15'h0000, serial_irq_req});
        check("oe", 16'h0001, {15'h0000, gen_clk_out_oe});
        $display("test timer mode done");
        conclude();
    end
endmodule // testbench

`default_nettype wire
